// >>> slem_pkg.sv
// Constants and types for the serial link error monitor
// What this block does
// [R1] Three-bit error status: absent clock, burst count, incomplete word.
// [R2] Diagnostic word during writes starts with fixed alternating pattern.
// [R3] Diagnostic word ends with the three status bits.
// [R4] First captured error locks status until it is cleared.
// [R5] Interrupt request raised on link error when enable bit set.
// [R6] Error state accepts only the status-read recovery command word.
// [R7] Recovery sends one word, then leaves error state, drops interrupt.
// [R8] General config target before error: reply is code, status cleared.
// [R9] Other target: undefined reply, only error state cleared.
// [R10] Chip select low with system clock stopped sets absent-clock flag.
// [R11] Burst word total differing from command count sets burst flag.
// [R12] Gap-tolerant mode: idle beyond timeout aborts transfer, burst flag.
// [R13] Framed mode nonzero count: mismatch flags; surplus word still written.
// [R14] Word with wrong bit total sets incomplete-word flag.
// [R15] Bit-total error under one chip select shows at frame end.
// [R16] Status reads zero in error-free operation and after reset.
// [R17] Gap-tolerant mode: word gap limited by timeout; select may toggle.
// [R18] Framed mode: select low whole frame, first word is command.
// [R19] Command: bit 15 direction, ten-bit address, five-bit word count.
package slem_pkg;
  localparam int WORD_W = 16;
  localparam int ADDR_W = 10;
  localparam int CNT_W = 5;
  localparam int SEL_W = 3;
  localparam int STAT_W = 3;
  localparam int WD_W = 8;
  // Command word layout
  localparam int CMD_DIR_BIT = 15;
  localparam int CMD_ADDR_LSB = 5;
  localparam int CMD_CNT_LSB = 0;
  // Status register offset and layout
  localparam logic [ADDR_W-1:0] STATUS_OFS = 10'h1d3;
  localparam logic [WORD_W-1:0] STATUS_RST = 16'h0000;
  localparam int ST_CKSYS_BIT = 2;
  localparam int ST_FRAME_BIT = 1;
  localparam int ST_WORD_BIT = 0;
  // Diagnostic pattern in the upper bits, status in the low three
  localparam logic [WORD_W-1:0] DIAG_PATTERN = 16'haaa8;
  localparam logic [WORD_W-1:0] RECOVER_CMD = 16'hba61;
  localparam logic [WORD_W-1:0] REPLY_UNDEF = 16'h0000;
  localparam logic [SEL_W-1:0] SEL_GEN_CFG = 3'h4;
  // Watchdog tick: one timeout unit is a microsecond
  localparam int CLK_PERIOD_PS = 8000;
  localparam int WD_UNIT_NS = 1000;
  localparam int WD_UNIT_CYC = (WD_UNIT_NS * 1000) / CLK_PERIOD_PS;
  localparam int WD_CNT_W = 16;
  // Pin synchroniser width and idle values: csb, sclk, mosi, cksys_ok
  localparam int SYNC_W = 4;
  localparam logic [SYNC_W-1:0] SYNC_RST = 4'h9;
  localparam logic [3:0] BITS_LAST = 4'hf;
  localparam logic [3:0] BITS_ZERO = 4'h0;
  typedef enum logic [1:0] {
    SLEM_CMD,
    SLEM_DATA,
    SLEM_ERR,
    SLEM_REPLY
  } slem_state_t;
endpackage

// >>> slem_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module slem_sync (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic [slem_pkg::SYNC_W-1:0] pin_in,
  output logic [slem_pkg::SYNC_W-1:0] pin_out
);
  import slem_pkg::*;

  logic [SYNC_W-1:0] meta_ff;
  logic [SYNC_W-1:0] s2_ff;
  logic [SYNC_W-1:0] s3_ff;
  logic [SYNC_W-1:0] out_ff;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_ff <= SYNC_RST;
      s2_ff <= SYNC_RST;
      s3_ff <= SYNC_RST;
    end else begin
      meta_ff <= pin_in;
      s2_ff <= meta_ff;
      s3_ff <= s2_ff;
    end
  end

  // A bit changes only once stages two and three agree
  genvar i;
  generate
    for (i = 0; i < SYNC_W; i++) begin : g_bit
      always_ff @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
          out_ff[i] <= SYNC_RST[i];
        end else if (s2_ff[i] == s3_ff[i]) begin
          out_ff[i] <= s3_ff[i];
        end
      end
    end
  endgenerate

  assign pin_out = out_ff;
endmodule

// >>> slem_monitor.sv
// Serial link slave protocol with error monitor and status register
`timescale 1ns/1ps
module slem_monitor (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic spi_csb_n,
  input wire logic spi_sclk,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic cksys_ok,
  input wire logic cfg_mode_a,
  input wire logic cfg_irq_en,
  input wire logic [slem_pkg::WD_W-1:0] cfg_wd_timeout,
  input wire logic [slem_pkg::SEL_W-1:0] sel_target,
  output logic wr_strobe,
  output logic [slem_pkg::ADDR_W-1:0] wr_addr,
  output logic [slem_pkg::WORD_W-1:0] wr_data,
  output logic [slem_pkg::ADDR_W-1:0] rd_addr,
  input wire logic [slem_pkg::WORD_W-1:0] rd_data,
  output logic [slem_pkg::WORD_W-1:0] err_status,
  output logic proto_error,
  output logic irq_req
);
  import slem_pkg::*;

  logic [SYNC_W-1:0] pins_s;
  logic csb_s;
  logic sclk_s;
  logic mosi_s;
  logic ckok_s;
  logic csb_prev_ff;
  logic sclk_prev_ff;
  logic sclk_rise;
  logic csb_fall;
  logic csb_rise;
  logic [3:0] bit_cnt_ff;
  logic [WORD_W-1:0] rx_sh_ff;
  logic [WORD_W-1:0] rx_word;
  logic word_done;
  logic [WORD_W-1:0] tx_sh_ff;
  logic load_ff;
  logic [WORD_W-1:0] nxt_tx;
  logic miso_oe_ff;
  slem_state_t state_ff;
  slem_state_t nxt_state;
  logic rd_dir_ff;
  logic [ADDR_W-1:0] addr_ff;
  logic [CNT_W-1:0] num_ff;
  logic [CNT_W-1:0] wcnt_ff;
  logic [WD_CNT_W-1:0] wd_cnt_ff;
  logic [WD_CNT_W-1:0] wd_limit;
  logic [STAT_W-1:0] status_ff;
  logic [STAT_W-1:0] err_vec;
  logic err_any;
  logic sel_at_err_ff;
  logic [WORD_W-1:0] reply_ff;
  logic recover;
  logic status_rd_clr;
  logic status_clr;
  logic is_data_word;
  logic wr_strobe_ff;
  logic [ADDR_W-1:0] wr_addr_ff;
  logic [WORD_W-1:0] wr_data_ff;

  // Pins come from the master's domain; sclk is sampled, not a clock
  slem_sync u_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pin_in({spi_csb_n, spi_sclk, spi_mosi, cksys_ok}),
    .pin_out(pins_s)
  );

  assign csb_s = pins_s[3];
  assign sclk_s = pins_s[2];
  assign mosi_s = pins_s[1];
  assign ckok_s = pins_s[0];

  // Edge history of the filtered pins
  // Reset values equal the idle pins, so no false edge follows reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      csb_prev_ff <= 1'b1;
      sclk_prev_ff <= 1'b0;
    end else begin
      csb_prev_ff <= csb_s;
      sclk_prev_ff <= sclk_s;
    end
  end

  // Only rising sclk edges inside a selected frame count as bits
  assign sclk_rise = sclk_s & ~sclk_prev_ff & ~csb_s;
  assign csb_fall = ~csb_s & csb_prev_ff;
  assign csb_rise = csb_s & ~csb_prev_ff;
  assign word_done = sclk_rise && (bit_cnt_ff == BITS_LAST);
  assign rx_word = {rx_sh_ff[WORD_W-2:0], mosi_s};

  // Bit counter spans the whole frame; a residue shows at select rise
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      bit_cnt_ff <= BITS_ZERO;
    end else if (csb_fall || csb_rise) begin
      bit_cnt_ff <= BITS_ZERO; // R15
    end else if (sclk_rise) begin
      bit_cnt_ff <= bit_cnt_ff + 4'h1;
    end
  end

  // Receive shifter, MSB first
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_sh_ff <= '0;
    end else if (sclk_rise) begin
      rx_sh_ff <= rx_word;
    end
  end

  // Error detection; several may fire together and are all captured
  // Word error is judged only at select rise, never mid-frame
  always_comb begin
    err_vec = '0;
    err_vec[ST_CKSYS_BIT] = csb_fall && !ckok_s; // R10
    err_vec[ST_WORD_BIT] = csb_rise && (bit_cnt_ff != BITS_ZERO); // R14
    // Framed mode, nonzero count: short frame at select rise
    if (!cfg_mode_a && state_ff == SLEM_DATA && num_ff != '0) begin
      if (csb_rise && wcnt_ff < num_ff) begin
        err_vec[ST_FRAME_BIT] = 1'b1; // R11 R13
      end
      // Surplus word: it is still written, and flagged in the same cycle
      if (word_done && wcnt_ff == num_ff) begin
        err_vec[ST_FRAME_BIT] = 1'b1; // R13
      end
    end
    // Gap-tolerant mode: watchdog expiry aborts the transfer
    if (cfg_mode_a && state_ff == SLEM_DATA && wd_limit != '0 &&
        wd_cnt_ff >= wd_limit) begin
      err_vec[ST_FRAME_BIT] = 1'b1; // R12
    end
  end

  assign err_any = |err_vec;

  // Timeout is in microseconds; zero disables the watchdog
  assign wd_limit = WD_CNT_W'({8'h00, cfg_wd_timeout} * WD_UNIT_CYC);

  // Idle counter restarts on every bit; select may toggle between words
  // It saturates, so a very long idle cannot wrap into a fresh start
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wd_cnt_ff <= '0;
    end else if (state_ff != SLEM_DATA || sclk_rise) begin
      wd_cnt_ff <= '0; // R17
    end else if (wd_cnt_ff != {WD_CNT_W{1'b1}}) begin
      wd_cnt_ff <= wd_cnt_ff + 16'h0001;
    end
  end

  assign recover = (state_ff == SLEM_ERR) && word_done &&
                   (rx_word == RECOVER_CMD);
  assign is_data_word = (state_ff == SLEM_DATA) && word_done;

  // Protocol sequencing
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      SLEM_CMD: begin
        // First word of a frame is the command word
        if (word_done) begin
          nxt_state = SLEM_DATA; // R18
          // Gap-tolerant mode with zero count is not a burst here
          if (cfg_mode_a && rx_word[CNT_W-1:0] == '0) begin
            nxt_state = SLEM_CMD;
          end
        end
      end
      SLEM_DATA: begin
        if (cfg_mode_a && word_done && wcnt_ff + 5'h01 == num_ff) begin
          nxt_state = SLEM_CMD;
        end else if (!cfg_mode_a && csb_rise) begin
          nxt_state = SLEM_CMD;
        end
      end
      SLEM_ERR: begin
        if (recover) begin
          nxt_state = SLEM_REPLY; // R6
        end
      end
      SLEM_REPLY: begin
        // Exactly one word goes out, then the link is usable again
        if (word_done) begin
          nxt_state = SLEM_CMD; // R7
        end else if (csb_rise) begin
          nxt_state = SLEM_ERR;
        end
      end
    endcase
    if (err_any && state_ff != SLEM_REPLY) begin
      nxt_state = SLEM_ERR; // R6
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= SLEM_CMD;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Command decode and per-word address and count tracking
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_dir_ff <= 1'b0;
      addr_ff <= '0;
      num_ff <= '0;
      wcnt_ff <= '0;
    end else if (state_ff == SLEM_CMD && word_done) begin
      rd_dir_ff <= rx_word[CMD_DIR_BIT]; // R19
      addr_ff <= rx_word[CMD_ADDR_LSB +: ADDR_W]; // R19
      num_ff <= rx_word[CMD_CNT_LSB +: CNT_W]; // R19
      wcnt_ff <= '0;
    end else if (is_data_word) begin
      addr_ff <= addr_ff + 10'h001;
      wcnt_ff <= wcnt_ff + 5'h01; // R11
    end
  end

  // Write port; a surplus word in framed mode is still committed
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_strobe_ff <= 1'b0;
      wr_addr_ff <= '0;
      wr_data_ff <= '0;
    end else begin
      wr_strobe_ff <= is_data_word && !rd_dir_ff; // R13
      if (is_data_word && !rd_dir_ff) begin
        wr_addr_ff <= addr_ff;
        wr_data_ff <= rx_word;
      end
    end
  end

  assign wr_strobe = wr_strobe_ff;
  assign wr_addr = wr_addr_ff;
  assign wr_data = wr_data_ff;
  assign rd_addr = addr_ff;

  // Target chosen before the error decides the recovery reply
  // Taken on each error that enters the error state; later faults there must not move it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sel_at_err_ff <= 1'b0;
    end else if (err_any && state_ff != SLEM_ERR &&
                 state_ff != SLEM_REPLY) begin
      sel_at_err_ff <= (sel_target == SEL_GEN_CFG); // R8
    end
  end

  // Reply word is fixed when the recovery command lands
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      reply_ff <= REPLY_UNDEF;
    end else if (recover) begin
      if (sel_at_err_ff) begin
        reply_ff <= {{(WORD_W-STAT_W){1'b0}}, status_ff}; // R8
      end else begin
        reply_ff <= REPLY_UNDEF; // R9
      end
    end
  end

  // Normal read of the status word clears it when the general config target is selected
  // Limitation: the clear happens at load, so a frame cut before the
  // word is shifted out still loses the code
  assign status_rd_clr = load_ff && state_ff == SLEM_DATA && rd_dir_ff &&
                         addr_ff == STATUS_OFS && sel_target == SEL_GEN_CFG;
  assign status_clr = status_rd_clr || (recover && sel_at_err_ff); // R8

  // First error locks the status; a new error beats a same-cycle clear
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      status_ff <= STATUS_RST[STAT_W-1:0]; // R16
    end else if (err_any && (status_ff == '0 || status_clr)) begin
      status_ff <= err_vec; // R4
    end else if (status_clr) begin
      status_ff <= '0; // R8
    end
  end

  // Upper bits of the status word are always zero
  assign err_status = {{(WORD_W-STAT_W){1'b0}}, status_ff}; // R1

  // Next outgoing word, chosen one cycle after the word boundary
  always_comb begin
    if (state_ff == SLEM_REPLY) begin
      nxt_tx = reply_ff; // R7
    end else if (state_ff == SLEM_DATA && rd_dir_ff) begin
      if (addr_ff == STATUS_OFS) begin
        nxt_tx = err_status;
      end else begin
        nxt_tx = rd_data;
      end
    end else begin
      nxt_tx = DIAG_PATTERN | err_status; // R2 R3
    end
  end

  // Load one cycle late so address and state have settled
  // The extra cycle stays well inside the master's half period
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      load_ff <= 1'b0;
    end else begin
      load_ff <= csb_fall || word_done;
    end
  end

  // Transmit shifter; MISO moves on rising sclk, master samples just before the next rising edge
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_sh_ff <= DIAG_PATTERN;
    end else if (load_ff) begin
      tx_sh_ff <= nxt_tx;
    end else if (sclk_rise) begin
      tx_sh_ff <= {tx_sh_ff[WORD_W-2:0], 1'b0};
    end
  end

  // Drive MISO only while selected
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      miso_oe_ff <= 1'b0;
    end else begin
      miso_oe_ff <= ~csb_s;
    end
  end

  assign spi_miso = tx_sh_ff[WORD_W-1];
  assign spi_miso_oe = miso_oe_ff;

  // Interrupt follows the error state, dropped by recovery
  assign proto_error = (state_ff == SLEM_ERR) || (state_ff == SLEM_REPLY);
  assign irq_req = cfg_irq_en && proto_error; // R5 R7
endmodule

// >>> slem_monitor_assertions.sv
// Port-level property checker for the serial link error monitor
`timescale 1ns/1ps
module slem_monitor_assertions (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic spi_csb_n,
  input wire logic spi_miso_oe,
  input wire logic cksys_ok,
  input wire logic cfg_irq_en,
  input wire logic wr_strobe,
  input wire logic [slem_pkg::WORD_W-1:0] err_status,
  input wire logic proto_error,
  input wire logic irq_req
);
  import slem_pkg::*;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // Status layout and first-error lock
  a_status_upper_zero: assert property (err_status[15:3] == 13'h0)
    else $error("status upper bits not zero");
  a_status_locked: assert property (err_status != 16'h0 |=>
    err_status == $past(err_status) || err_status == 16'h0)
    else $error("status changed while locked");
  a_error_state: assert property ($rose(err_status != 16'h0) |->
    ##[0:2] proto_error)
    else $error("error captured without error state");
  // Interrupt is a plain gate of the error state
  a_irq_gate: assert property (irq_req == (cfg_irq_en && proto_error))
    else $error("interrupt does not follow error state");
  // Select low with the system clock stopped flags within the sync delay
  a_cksys_flag: assert property (($fell(spi_csb_n) && !cksys_ok &&
    err_status == 16'h0) |-> ##[1:16] err_status[2])
    else $error("absent clock not flagged");
  // Output enable tracks the select after the pin filter
  a_oe_active: assert property ((!spi_csb_n)[*8] |-> spi_miso_oe)
    else $error("miso not driven during frame");
  a_oe_idle: assert property (spi_csb_n[*8] |-> !spi_miso_oe)
    else $error("miso driven outside frame");
  // One strobe per word, none while parked in the error state
  a_strobe_single: assert property (wr_strobe |=> !wr_strobe)
    else $error("write strobe longer than one cycle");
  a_no_write_err: assert property (($past(proto_error, 2) &&
    proto_error) |-> !wr_strobe)
    else $error("write while in error state");
  c_write: cover property (wr_strobe);
  c_irq: cover property ($rose(irq_req));
  c_recover: cover property ($fell(proto_error));
endmodule

// >>> slem_host_model.sv
// Host-side serial master model driving the link pins
`timescale 1ns/1ps
module slem_host_model (
  output logic spi_csb_n,
  output logic spi_sclk,
  output logic spi_mosi,
  input wire logic spi_miso
);
  // Half of the 64 ns link period: four system cycles per phase
  localparam int HALF = 32;
  // Idle link: select high, clock stopped low
  initial begin
    spi_csb_n = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
  end
  // Frame edge with settle time on both sides; data scrambled when idle
  task automatic sel(input logic on);
    #(4 * HALF);
    spi_csb_n = !on;
    spi_mosi = !spi_mosi;
    #(4 * HALF);
  endtask
  // One word MSB first; reply sampled just before each rising edge
  task automatic word(input logic [15:0] w, input int nb,
                      output logic [15:0] rx);
    rx = 16'h0;
    for (int i = 0; i < nb; i++) begin
      spi_mosi = w[15 - i];
      #HALF;
      rx = {rx[14:0], spi_miso};
      spi_sclk = 1'b1;
      #HALF;
      spi_sclk = 1'b0;
    end
    spi_mosi = !spi_mosi; // Hold time over, so no stale level
    #HALF; // A following word must not drive data in this time step
  endtask
endmodule

// >>> slem_monitor_tb.sv
// Self-checking bench for the serial link error monitor
`timescale 1ns/1ps
module slem_monitor_tb;
  import slem_pkg::*;
  logic sys_clk, arst_n, cksys_ok, cfg_mode_a, cfg_irq_en;
  logic spi_csb_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe;
  logic wr_strobe, proto_error, irq_req;
  logic miso_line;
  logic [WD_W-1:0] cfg_wd_timeout;
  logic [SEL_W-1:0] sel_target;
  logic [ADDR_W-1:0] wr_addr, rd_addr, a;
  logic [WORD_W-1:0] wr_data, rd_data, err_status, rx, d, st;
  logic [25:0] exp_q[$];
  logic [25:0] note;
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;
  // Memory stand-in: read data is a fixed function of the address
  assign rd_data = {6'h15, rd_addr} ^ 16'h0f0f;
  // A released line shows the inverse, so early sampling is caught
  assign miso_line = spi_miso_oe ? spi_miso : ~spi_miso;
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  slem_monitor slem_monitor_inst (.sys_clk, .arst_n, .spi_csb_n, .spi_sclk,
    .spi_mosi, .spi_miso, .spi_miso_oe, .cksys_ok, .cfg_mode_a, .cfg_irq_en,
    .cfg_wd_timeout, .sel_target, .wr_strobe, .wr_addr, .wr_data, .rd_addr,
    .rd_data, .err_status, .proto_error, .irq_req);
  slem_host_model slem_host_model_inst (.spi_csb_n, .spi_sclk, .spi_mosi,
    .spi_miso(miso_line));
  task automatic check(input string what, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic cs(input logic on);
    slem_host_model_inst.sel(on);
  endtask
  task automatic xw(input logic [15:0] w, input int nb = 16);
    slem_host_model_inst.word(w, nb, rx);
  endtask
  // Command plus data words; notes pushed before the word is sent
  task automatic burst(input logic rd, input int n, sent, tail);
    cs(1);
    xw({rd, a, n[4:0]});
    for (int i = 0; i < sent; i++) begin
      d = 16'($urandom);
      if (cfg_mode_a) begin
        cs(0);
        cs(1);
      end
      if (!rd) exp_q.push_back({a + i[9:0], d});
      xw(d);
      if (rd) check("read", rx, {6'h15, a + i[9:0]} ^ 16'h0f0f);
      else check("diag", rx, DIAG_PATTERN | st);
    end
    if (tail > 0) xw(16'hffff, tail);
    cs(0);
    tick(20);
  endtask
  task automatic expect_err(input logic [2:0] code);
    st = {13'h0, code};
    check("status", err_status, st);
    check("irq", {15'h0, irq_req}, {15'h0, cfg_irq_en});
  endtask
  task automatic recover(input logic [15:0] exp);
    cs(1);
    xw(RECOVER_CMD);
    check("diag in error", rx, DIAG_PATTERN | st);
    xw(16'h0);
    cs(0);
    tick(4);
    check("reply", rx, exp);
    check("err state", {15'h0, proto_error}, 16'h0);
    check("irq off", {15'h0, irq_req}, 16'h0);
  endtask
  // Each strobe takes the oldest note; settled values read mid-cycle
  always @(negedge sys_clk) begin
    if (wr_strobe === 1'b1) begin
      if (exp_q.size() == 0) begin
        check("write count", 16'h1, 16'h0);
      end else begin
        note = exp_q.pop_front();
        check("wr addr", {6'h0, wr_addr}, {6'h0, note[25:16]});
        check("wr data", wr_data, note[15:0]);
      end
    end
  end
  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 40000) begin
      fails++;
      $display("ERROR timeout expected done seen hang");
      finish_test();
    end
  end
  initial begin
    void'($urandom(88));
    arst_n = 0; cksys_ok = 1; cfg_mode_a = 0; cfg_irq_en = 1;
    cfg_wd_timeout = 8'h1; sel_target = SEL_GEN_CFG; st = 16'h0; a = 0;
    tick(16);
    arst_n = 1;
    tick(8);
    check("status reset", err_status, STATUS_RST);
    $display("test reset done");
    // Window kept above the status offset so reads see plain memory
    a = 10'($urandom_range(480, 1000));
    burst(0, 2, 2, 0);
    burst(1, 3, 3, 0);
    check("status clean", err_status, STATUS_RST);
    $display("test framed transfers done");
    burst(0, 3, 1, 0);
    expect_err(3'h2);
    cs(1);
    xw(16'h1234, 9);
    cs(0);
    tick(20);
    expect_err(3'h2);
    recover(16'h0002);
    check("cleared", err_status, STATUS_RST);
    $display("test short burst done");
    cfg_irq_en = 0; sel_target = 3'h1; st = 16'h0;
    burst(0, 1, 2, 0);
    expect_err(3'h2);
    recover(REPLY_UNDEF);
    check("kept", err_status, st);
    sel_target = SEL_GEN_CFG;
    cs(1);
    xw({1'b1, STATUS_OFS, 5'd1});
    xw(16'h0);
    cs(0);
    tick(4);
    check("status read", rx, st);
    check("read clears", err_status, STATUS_RST);
    $display("test overlong burst done");
    cfg_irq_en = 1; st = 16'h0;
    burst(0, 0, 1, 12);
    expect_err(3'h1);
    recover(16'h0001);
    cksys_ok = 0; st = 16'h0;
    cs(1);
    cs(0);
    tick(20);
    expect_err(3'h4);
    cksys_ok = 1;
    recover(16'h0004);
    $display("test bit count and clock done");
    cfg_mode_a = 1; st = 16'h0;
    burst(0, 1, 1, 0);
    burst(0, 3, 1, 0);
    tick(300);
    expect_err(3'h2);
    recover(16'h0002);
    cfg_mode_a = 0;
    $display("test gap mode done");
    check("notes left", 16'(exp_q.size()), 16'h0);
    finish_test();
  end
endmodule
bind slem_monitor slem_monitor_assertions slem_monitor_assertions_inst (
  .sys_clk, .arst_n, .spi_csb_n, .spi_miso_oe, .cksys_ok, .cfg_irq_en,
  .wr_strobe, .err_status, .proto_error, .irq_req);
